// file: core/scas_config_slave.sv
// Management-bus slave reaching the per-port switch configuration words
`timescale 1ns/1ps
`default_nettype none
`include "scas_consts.svh"

module scas_config_slave (
   input  wire logic        clk,             // Core clock
   input  wire logic        rst,             // Async reset, active high
   input  wire logic        mgmtClockLineIn, // Clock line level, link clock
   output logic             mgmtClockLineOut,// Clock line drive value
   output logic             mgmtClockLineOe, // Clock line drive enable
   input  wire logic        mgmtDataLineIn,  // Data line level
   output logic             mgmtDataLineOut, // Data line drive value
   output logic             mgmtDataLineOe,  // Data line drive enable
   input  wire logic [2:0]  addrStrap,       // Address pins, bit 2 first on the bus
   input  wire logic        eeLoadValid,     // Loader word strobe
   input  wire logic [7:0]  eeLoadAddr,      // Loader word location
   input  wire logic [15:0] eeLoadData,      // Loader word
   input  wire logic        cfgReq,          // Config access request
   input  wire logic        cfgWrite,        // Config access is a write
   input  wire logic [1:0]  cfgPort,         // Config access port
   input  wire logic [8:0]  cfgOffset,       // Config access offset
   input  wire logic [31:0] cfgWdata,        // Config write data
   output logic             cfgAck,          // Config access taken
   output logic [31:0]      cfgRdata         // Config read data
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   scas_pkg::scas_link_state_t linkState_q;
   logic        startTgl_q;
   logic        startSeen_q;
   logic        startUsed_q;
   logic        frameStart;
   logic [3:0]  bitCnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  byteIn;
   logic        ackMe_q;
   logic        loadRd_q;
   logic        sdaOe_q;
   logic        reqTgl_q;
   logic        reqWrite_q;
   logic [1:0]  reqPort_q;
   logic [1:0]  dataCnt_q;
   logic [8:0]  reqOffset_q;
   logic [31:0] reqWdata_q;
   logic [31:0] rdShift_q;
   logic [2:0]  strapLink;
   logic        ackLink;
   logic [2:0]  strapSync;
   logic [2:0]  strap_q;
   logic [1:0]  strapWait_q;
   logic        strapDone_q;
   logic [6:0]  slvAddr;
   logic        reqSync;
   logic        reqSeen_q;
   logic        smbPend_q;
   logic        smbServe;
   logic        ackTgl_q;
   logic [31:0] rdHold_q;
   logic [31:0] regs_q [16];
   logic [2:0]  cfgDec;
   logic [2:0]  smbDec;
   logic [3:0]  cfgIdx;
   logic [3:0]  smbIdx;
   logic        wrEn;
   logic [3:0]  wrIdx;
   logic [31:0] wrData;
   logic [15:0] eeDataPast_q;

   function automatic logic [2:0] regSel(input logic [8:0] off);
      logic [2:0] r;
      r = 3'h0;
      case (off)
         `SCAS_OFF_RETRY: r = 3'h4;
         `SCAS_OFF_TSCTL: r = 3'h5;
         `SCAS_OFF_SLOTS: r = 3'h6;
         `SCAS_OFF_TCMAP: r = 3'h7;
         default:         r = 3'h0;
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Pins
   // ---------------------------------------------------------------
   // Open drain: only ever pulls low; the clock is never stretched
   assign mgmtDataLineOut  = 1'b0;
   assign mgmtDataLineOe   = sdaOe_q;
   assign mgmtClockLineOut = 1'b0;
   assign mgmtClockLineOe  = 1'b0;

   // ---------------------------------------------------------------
   // Link domain: start detection
   // ---------------------------------------------------------------
   always_ff @(negedge mgmtDataLineIn or posedge rst) begin
      if (rst) begin
         startTgl_q <= 1'b0;
      end else if (mgmtClockLineIn) begin
         startTgl_q <= ~startTgl_q;
      end
   end

   // Toggle is stable for the whole start hold time before this edge
   always_ff @(negedge mgmtClockLineIn or posedge rst) begin
      if (rst) begin
         startSeen_q <= 1'b0;
         sdaOe_q     <= 1'b0;
      end else begin
         startSeen_q <= startTgl_q;
         if (bitCnt_q == 4'h8) begin
            sdaOe_q <= ackMe_q;
         end else begin
            sdaOe_q <= (linkState_q == scas_pkg::LK_RDATA) && !rdShift_q[31];
         end
      end
   end

   assign frameStart = startSeen_q != startUsed_q;
   assign byteIn     = {shift_q[6:0], mgmtDataLineIn};

   scas_sync #(.WIDTH(3)) uStrapLink (
      .clk (mgmtClockLineIn),
      .rst (rst),
      .d   (strap_q),
      .q   (strapLink)
   );

   scas_sync #(.WIDTH(1)) uAckLink (
      .clk (mgmtClockLineIn),
      .rst (rst),
      .d   (ackTgl_q),
      .q   (ackLink)
   );

   // ---------------------------------------------------------------
   // Link domain: bit and byte engine
   // ---------------------------------------------------------------
   always_ff @(posedge mgmtClockLineIn or posedge rst) begin
      if (rst) begin
         linkState_q <= scas_pkg::LK_IDLE;
         startUsed_q <= 1'b0;
         bitCnt_q    <= 4'h0;
         shift_q     <= 8'h00;
         ackMe_q     <= 1'b0;
         loadRd_q    <= 1'b0;
         reqTgl_q    <= 1'b0;
         reqWrite_q  <= 1'b0;
         reqPort_q   <= 2'h0;
         dataCnt_q   <= 2'h0;
         reqOffset_q <= 9'h000;
         reqWdata_q  <= 32'h0000_0000;
         rdShift_q   <= 32'hFFFF_FFFF;
      end else if (frameStart) begin
         startUsed_q <= startSeen_q;
         linkState_q <= scas_pkg::LK_ADDR;
         bitCnt_q    <= 4'h1;
         shift_q     <= {7'h00, mgmtDataLineIn};
         ackMe_q     <= 1'b0;
         loadRd_q    <= 1'b0;
      end else if (bitCnt_q == 4'h8) begin
         bitCnt_q <= 4'h0;
         if (loadRd_q) begin
            loadRd_q  <= 1'b0;
            // Answer only once the core has handed the word over
            rdShift_q <= (ackLink == reqTgl_q) ? rdHold_q : `SCAS_RD_UNREADY;
         end else if (linkState_q == scas_pkg::LK_RDATA && mgmtDataLineIn) begin
            linkState_q <= scas_pkg::LK_IDLE;
         end
      end else begin
         bitCnt_q <= bitCnt_q + 4'h1;
         shift_q  <= byteIn;
         if (linkState_q == scas_pkg::LK_RDATA) begin
            rdShift_q <= {rdShift_q[30:0], 1'b1};
         end
         if (bitCnt_q == 4'h7) begin
            ackMe_q <= 1'b0;
            case (linkState_q)
               scas_pkg::LK_ADDR: begin
                  if (byteIn[7:1] == {`SCAS_ADDR_FIXED, strapLink}) begin
                     ackMe_q     <= 1'b1;
                     loadRd_q    <= byteIn[0];
                     linkState_q <= byteIn[0] ? scas_pkg::LK_RDATA : scas_pkg::LK_CMD;
                  end else begin
                     linkState_q <= scas_pkg::LK_IDLE;
                  end
               end
               scas_pkg::LK_CMD: begin
                  ackMe_q        <= 1'b1;
                  reqPort_q      <= byteIn[5:4];
                  reqOffset_q[8] <= byteIn[0];
                  linkState_q    <= scas_pkg::LK_OFFSET;
               end
               scas_pkg::LK_OFFSET: begin
                  // Prefetch the word so a following read has it ready
                  ackMe_q          <= 1'b1;
                  reqOffset_q[7:0] <= byteIn;
                  dataCnt_q        <= 2'h0;
                  reqWrite_q       <= 1'b0;
                  reqTgl_q         <= ~reqTgl_q;
                  linkState_q      <= scas_pkg::LK_WDATA;
               end
               scas_pkg::LK_WDATA: begin
                  ackMe_q    <= 1'b1;
                  reqWdata_q <= {reqWdata_q[23:0], byteIn};
                  dataCnt_q  <= dataCnt_q + 2'h1;
                  if (dataCnt_q == 2'h3) begin
                     reqWrite_q <= 1'b1;
                     reqTgl_q   <= ~reqTgl_q;
                  end
               end
               default: begin
                  ackMe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Core domain: strap capture
   // ---------------------------------------------------------------
   scas_sync #(.WIDTH(3)) uStrapSync (
      .clk (clk),
      .rst (rst),
      .d   (addrStrap),
      .q   (strapSync)
   );

   // Pins are caught once, after the synchroniser has filled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strapWait_q <= 2'h0;
         strapDone_q <= 1'b0;
         strap_q     <= 3'h0;
      end else if (!strapDone_q) begin
         strapWait_q <= strapWait_q + 2'h1;
         if (strapWait_q == `SCAS_STRAP_WAIT) begin
            strap_q     <= strapSync;
            strapDone_q <= 1'b1;
         end
      end
   end

   assign slvAddr = {`SCAS_ADDR_FIXED, strap_q};

   // ---------------------------------------------------------------
   // Core domain: access arbitration, loader first
   // ---------------------------------------------------------------
   scas_sync #(.WIDTH(1)) uReqSync (
      .clk (clk),
      .rst (rst),
      .d   (reqTgl_q),
      .q   (reqSync)
   );

   assign cfgDec   = regSel(cfgOffset);
   assign smbDec   = regSel(reqOffset_q);
   assign cfgIdx   = {cfgPort, cfgDec[1:0]};
   assign smbIdx   = {reqPort_q, smbDec[1:0]};
   assign cfgAck   = cfgReq && !eeLoadValid;
   assign smbServe = smbPend_q && !eeLoadValid && !cfgReq;

   always_comb begin
      wrEn   = 1'b0;
      wrIdx  = cfgIdx;
      wrData = cfgWdata;
      if (cfgAck && cfgWrite && cfgDec[2]) begin
         wrEn = 1'b1;
      end else if (smbServe && reqWrite_q && smbDec[2]) begin
         wrEn   = 1'b1;
         wrIdx  = smbIdx;
         wrData = reqWdata_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reqSeen_q <= 1'b0;
         smbPend_q <= 1'b0;
      end else begin
         reqSeen_q <= reqSync;
         if (reqSync != reqSeen_q) begin
            smbPend_q <= 1'b1;
         end else if (smbServe) begin
            smbPend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdHold_q <= 32'h0000_0000;
         ackTgl_q <= 1'b0;
      end else if (smbServe) begin
         rdHold_q <= smbDec[2] ? regs_q[smbIdx] : 32'h0000_0000;
         ackTgl_q <= ~ackTgl_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfgRdata <= 32'h0000_0000;
      end else if (cfgAck && !cfgWrite) begin
         cfgRdata <= cfgDec[2] ? regs_q[cfgIdx] : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Register storage, one entry per port and register
   // ---------------------------------------------------------------
   for (genvar e = 0; e < 16; e++) begin : gEntry
      localparam logic [1:0] SEL   = 2'(e % 4);
      localparam logic [7:0] PADDR = 8'(2 * (e / 4));
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            regs_q[e] <= `SCAS_REG_RESET;
         end else if (wrEn && wrIdx == 4'(e)) begin
            regs_q[e] <= wrData;
         end else if (eeLoadValid) begin
            if (SEL == 2'h0 && eeLoadAddr == `SCAS_EE_REPLAY_BASE + PADDR) begin
               regs_q[e][`SCAS_REPLAY_FLD] <= eeLoadData[`SCAS_EE_REPLAY_FLD];
            end
            if (SEL == 2'h0 && eeLoadAddr == `SCAS_EE_ACKLAT_BASE + PADDR) begin
               regs_q[e][`SCAS_ACKLAT_FLD] <= eeLoadData[`SCAS_EE_ACKLAT_FLD];
            end
            if (SEL == 2'h1 && eeLoadAddr == `SCAS_EE_REPLAY_BASE + PADDR) begin
               regs_q[e][`SCAS_TSCTL_FLD] <= eeLoadData[`SCAS_EE_TSCTL_FLD];
            end
            if (SEL == 2'h2 && eeLoadAddr == `SCAS_EE_VC_BASE + PADDR) begin
               regs_q[e][`SCAS_SLOT_FLD] <= eeLoadData[`SCAS_EE_SLOT_FLD];
            end
            if (SEL == 2'h3 && eeLoadAddr == `SCAS_EE_VC_BASE + PADDR) begin
               regs_q[e][`SCAS_TCMAP_FLD] <= eeLoadData[`SCAS_EE_TCMAP_FLD];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         eeDataPast_q <= 16'h0000;
      end else begin
         eeDataPast_q <= eeLoadData;
      end
   end

   ee_replay_load_a: assert property (@(posedge clk) disable iff (rst)
      eeLoadValid && eeLoadAddr == `SCAS_EE_REPLAY_BASE + `SCAS_EE_PORT3
      |=> regs_q[12][`SCAS_REPLAY_FLD] == eeDataPast_q[`SCAS_EE_REPLAY_FLD])
      else $error("port 3 replay field not loaded");

   ee_tsctl_load_a: assert property (@(posedge clk) disable iff (rst)
      eeLoadValid && eeLoadAddr == `SCAS_EE_REPLAY_BASE + `SCAS_EE_PORT3
      |=> regs_q[13][`SCAS_TSCTL_FLD] == eeDataPast_q[`SCAS_EE_TSCTL_FLD])
      else $error("port 3 training control not loaded");

   ack_latency_a: assert property (@(posedge clk) disable iff (rst)
      eeLoadValid && eeLoadAddr == `SCAS_EE_ACKLAT_BASE + `SCAS_EE_PORT3
      |=> regs_q[12][`SCAS_ACKLAT_FLD] == eeDataPast_q[`SCAS_EE_ACKLAT_FLD])
      else $error("port 3 ack latency not loaded");

   slot_load_a: assert property (@(posedge clk) disable iff (rst)
      eeLoadValid && eeLoadAddr == `SCAS_EE_VC_BASE
      |=> regs_q[2][`SCAS_SLOT_FLD] == eeDataPast_q[`SCAS_EE_SLOT_FLD])
      else $error("port 0 time slot not loaded");

   class_map_a: assert property (@(posedge clk) disable iff (rst)
      eeLoadValid && eeLoadAddr == `SCAS_EE_VC_BASE + `SCAS_EE_PORT3
      |=> regs_q[15][`SCAS_TCMAP_FLD] == eeDataPast_q[`SCAS_EE_TCMAP_FLD])
      else $error("port 3 class map not loaded");

   shared_write_a: assert property (@(posedge clk) disable iff (rst)
      smbServe && reqWrite_q && smbDec[2]
      |=> regs_q[$past(smbIdx)] == $past(reqWdata_q) && cfgRdata == $past(cfgRdata))
      else $error("bus write did not reach storage");

   cfg_read_a: assert property (@(posedge clk) disable iff (rst)
      cfgAck && !cfgWrite && cfgDec[2] |=> cfgRdata == regs_q[$past(cfgIdx)])
      else $error("config read returned wrong word");

   strap_catch_a: assert property (@(posedge clk) disable iff (rst)
      $rose(strapDone_q) |-> slvAddr[2:0] == $past(strapSync) && strapWait_q == 2'h0)
      else $error("strap not caught into address");

   addr_nack_a: assert property (@(posedge mgmtClockLineIn) disable iff (rst)
      !frameStart && bitCnt_q == 4'h7 && linkState_q == scas_pkg::LK_ADDR
      && byteIn[7:4] != `SCAS_ADDR_FIXED |=> !ackMe_q && linkState_q == scas_pkg::LK_IDLE)
      else $error("foreign address acknowledged");

   idle_release_a: assert property (@(posedge mgmtClockLineIn) disable iff (rst)
      linkState_q == scas_pkg::LK_IDLE && bitCnt_q != 4'h0 |-> !sdaOe_q)
      else $error("data line driven while idle");

endmodule

`default_nettype wire

// file: shared/scas_consts.svh
// Offsets, field positions, load map and reset values of the config access slave
`ifndef SCAS_CONSTS_SVH
`define SCAS_CONSTS_SVH

// ---------------------------------------------------------------
// Per-port register offsets
// ---------------------------------------------------------------
`define SCAS_OFF_RETRY      9'h070
`define SCAS_OFF_TSCTL      9'h08C
`define SCAS_OFF_SLOTS      9'h15C
`define SCAS_OFF_TCMAP      9'h160

// ---------------------------------------------------------------
// Register fields
// ---------------------------------------------------------------
`define SCAS_REPLAY_FLD     12:0
`define SCAS_ACKLAT_FLD     30:16
`define SCAS_TSCTL_FLD      25:24
`define SCAS_SLOT_FLD       22:16
`define SCAS_TCMAP_FLD      7:0

// ---------------------------------------------------------------
// Loadable word map, one word per port, two bytes apart
// ---------------------------------------------------------------
`define SCAS_EE_REPLAY_BASE 8'hD0
`define SCAS_EE_ACKLAT_BASE 8'hE0
`define SCAS_EE_VC_BASE     8'hF0
`define SCAS_EE_PORT3       8'h06
`define SCAS_EE_REPLAY_FLD  12:0
`define SCAS_EE_TSCTL_FLD   14:13
`define SCAS_EE_ACKLAT_FLD  14:0
`define SCAS_EE_SLOT_FLD    6:0
`define SCAS_EE_TCMAP_FLD   15:8

// ---------------------------------------------------------------
// Slave address, reset values, timing
// ---------------------------------------------------------------
`define SCAS_ADDR_FIXED     4'hD
`define SCAS_REG_RESET      32'h0000_0000
`define SCAS_RD_UNREADY     32'hFFFF_FFFF
`define SCAS_STRAP_WAIT     2'h3

`endif

// file: shared/scas_pkg.sv
// Types shared by the config access slave
`default_nettype none

package scas_pkg;
   typedef enum logic [2:0] {
      LK_IDLE,
      LK_ADDR,
      LK_CMD,
      LK_OFFSET,
      LK_WDATA,
      LK_RDATA
   } scas_link_state_t;
endpackage

`default_nettype wire

// file: core/scas_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none

module scas_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,   // Destination clock
   input  wire logic             rst,   // Async reset, active high
   input  wire logic [WIDTH-1:0] d,     // Level from another domain
   output logic      [WIDTH-1:0] q      // Synchronised level
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule

`default_nettype wire

// file: verification/scas_smb_master.sv
// Management bus master model driving the two open-drain lines
`timescale 1ns/1ps
`default_nettype none

module scas_smb_master (
   output logic      sclOut,  // Clock line, 1 = released
   output logic      sdaOe,   // Data line pull-down enable
   input  wire logic sdaIn    // Data line level after pull-up
);
   // Both lines rest released (pulled high) between frames
   initial begin
      sclOut = 1'b1;
      sdaOe = 1'b0;
   end

   // Also serves as repeated start
   task automatic start();
      #2 sdaOe = 1'b0;
      #13 sclOut = 1'b1;
      #15 sdaOe = 1'b1;
      #15 sclOut = 1'b0;
   endtask

   task automatic stop();
      #2 sdaOe = 1'b1;
      #13 sclOut = 1'b1;
      #15 sdaOe = 1'b0;
   endtask

   // Data moves only while the clock is low, 2 ns clear of the edge
   task automatic bitIo(input logic b, output logic r);
      #2 sdaOe = ~b;
      #13 sclOut = 1'b1;
      r = sdaIn;
      #15 sclOut = 1'b0;
   endtask

   task automatic sendByte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(v[i], r);
      bitIo(1'b1, r);
      ack = ~r;
   endtask

   task automatic recvByte(input logic last, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(1'b1, v[i]);
      bitIo(last, r);
   endtask

   // Word write or read of any register, MSB byte first
   task automatic xfer(input logic [6:0] a, input logic rd, input logic [1:0] p,
                       input logic [8:0] off, inout logic [31:0] d, output logic ok);
      logic       k;
      logic [7:0] b;
      #7;
      start();
      sendByte({a, 1'b0}, ok);
      if (ok) begin
         sendByte({2'b00, p, 3'b000, off[8]}, k);
         ok = ok & k;
         sendByte(off[7:0], k);
         ok = ok & k;
         if (rd) begin
            start();
            sendByte({a, 1'b1}, k);
            ok = ok & k;
            for (int i = 3; i >= 0; i--) begin
               recvByte(i == 0, b);
               d[i*8 +: 8] = b;
            end
         end else begin
            for (int i = 3; i >= 0; i--) begin
               sendByte(d[i*8 +: 8], k);
               ok = ok & k;
            end
         end
      end
      stop();
   endtask
endmodule

`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench of the config access slave
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        clk, rst, eeLoadValid, cfgReq, cfgWrite, cfgAck, ok;
   logic        cOut, cOe, dOut, dOe, mScl, mSdaOe;
   logic [2:0]  addrStrap;
   logic [7:0]  eeLoadAddr;
   logic [15:0] eeLoadData;
   logic [1:0]  cfgPort, p;
   logic [8:0]  cfgOffset;
   logic [31:0] cfgWdata, cfgRdata, d, rd, seed;
   logic [31:0] expReg [4][4];
   logic [6:0]  addr;
   int          errorCnt, testsRun;
   wire logic   sclLine, sdaLine;
   localparam logic [8:0] OFFS [4] = '{9'h070, 9'h08C, 9'h15C, 9'h160};

   assign sclLine = mScl & ~(cOe & ~cOut);
   assign sdaLine = ~(mSdaOe | (dOe & ~dOut));

   scas_config_slave u_dut (.clk(clk), .rst(rst), .mgmtClockLineIn(sclLine),
      .mgmtClockLineOut(cOut), .mgmtClockLineOe(cOe), .mgmtDataLineIn(sdaLine),
      .mgmtDataLineOut(dOut), .mgmtDataLineOe(dOe), .addrStrap(addrStrap),
      .eeLoadValid(eeLoadValid), .eeLoadAddr(eeLoadAddr), .eeLoadData(eeLoadData),
      .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgPort(cfgPort), .cfgOffset(cfgOffset),
      .cfgWdata(cfgWdata), .cfgAck(cfgAck), .cfgRdata(cfgRdata));
   scas_smb_master u_master (.sclOut(mScl), .sdaOe(mSdaOe), .sdaIn(sdaLine));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic testDone();
      $display("checks %0d, mismatches %0d", testsRun, errorCnt);
      if (errorCnt == 0 && testsRun > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic cfgAcc(input logic w, input logic [1:0] pt, input logic [8:0] off,
                         input logic [31:0] wd, output logic [31:0] r);
      int n;
      @(posedge clk);
      cfgReq <= 1'b1;
      cfgWrite <= w;
      cfgPort <= pt;
      cfgOffset <= off;
      cfgWdata <= wd;
      for (n = 0; n < 20 && cfgAck !== 1'b1; n++) @(negedge clk);
      if (cfgAck !== 1'b1) begin
         errorCnt++;
         $display("wrong value at %0t: config access never taken", $time);
         testDone();
      end
      @(posedge clk);
      cfgReq <= 1'b0;
      #1 r = cfgRdata;
   endtask

   // Fields that one loader word should reach, other bits untouched
   function automatic void expLoad(input logic [7:0] a, input logic [15:0] w);
      int q;
      q = int'(a[2:1]);
      if (a[0] == 1'b0 && a[3] == 1'b0) begin
         case (a[7:4])
            4'hD: begin
               expReg[q][0][12:0] = w[12:0];
               expReg[q][1][25:24] = w[14:13];
            end
            4'hE: expReg[q][0][30:16] = w[14:0];
            4'hF: begin
               expReg[q][2][22:16] = w[6:0];
               expReg[q][3][7:0] = w[15:8];
            end
            default: ;
         endcase
      end
   endfunction

   task automatic loadWord(input logic [7:0] a, input logic [15:0] w);
      @(posedge clk);
      eeLoadValid <= 1'b1;
      eeLoadAddr <= a;
      eeLoadData <= w;
      @(posedge clk);
      eeLoadValid <= 1'b0;
      expLoad(a, w);
   endtask

   task automatic verifyAll();
      logic [31:0] r;
      for (int q = 0; q < 4; q++) begin
         for (int i = 0; i < 4; i++) begin
            cfgAcc(1'b0, q[1:0], OFFS[i], 32'h0000_0000, r);
            check(r, expReg[q][i], "register word");
         end
      end
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = $urandom(32'h3c013467);
      rst = 1'b1;
      {eeLoadValid, cfgReq, cfgWrite, eeLoadAddr, eeLoadData} = '0;
      {cfgPort, cfgOffset, cfgWdata} = '0;
      addrStrap = 3'($urandom);
      foreach (expReg[q, i]) expReg[q][i] = 32'h0000_0000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (12) @(posedge clk);
      addr = {1'b1, 1'b1, 1'b0, 1'b1, addrStrap};
      verifyAll();
      for (int q = 0; q < 4; q++) begin
         for (int k = 0; k < 3; k++) loadWord(8'hD0 + 8'(k * 16 + q * 2), 16'($urandom));
      end
      loadWord(8'hD8, 16'($urandom));
      verifyAll();
      // Full words first, then reloads must touch only their fields
      foreach (expReg[q, i]) begin
         expReg[q][i] = $urandom;
         cfgAcc(1'b1, q[1:0], OFFS[i], expReg[q][i], rd);
      end
      fork
         loadWord(8'hD6, 16'($urandom));
         cfgAcc(1'b0, 2'h3, OFFS[1], 32'h0000_0000, rd);
      join
      check(rd, expReg[3][1], "loader ahead of config read");
      loadWord(8'hF6, 16'hFFFF);
      loadWord(8'hE6, 16'h0000);
      verifyAll();
      cfgAcc(1'b1, 2'h0, 9'h074, 32'hFFFF_FFFF, rd);
      cfgAcc(1'b0, 2'h0, 9'h074, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000, "unmapped offset");
      for (int i = 0; i < 4; i++) begin
         p = 2'($urandom);
         d = $urandom;
         u_master.xfer(addr, 1'b0, p, OFFS[i], d, ok);
         check({31'h0, ok}, 32'h1, "bus write acked");
         repeat (20) @(posedge clk);
         expReg[p][i] = d;
      end
      verifyAll();
      for (int i = 0; i < 4; i++) begin
         p = 2'($urandom);
         u_master.xfer(addr, 1'b1, p, OFFS[i], d, ok);
         check({31'h0, ok}, 32'h1, "bus read acked");
         check(d, expReg[p][i], "bus read");
      end
      // Every single-bit error in the address, strap or fixed part
      for (int k = 0; k < 7; k++) begin
         d = $urandom;
         u_master.xfer(addr ^ 7'(1 << k), 1'b0, 2'h0, OFFS[0], d, ok);
         check({31'h0, ok}, 32'h0, "foreign address acked");
      end
      repeat (20) @(posedge clk);
      check({31'h0, cOe}, 32'h0, "clock line driven");
      check({31'h0, dOe}, 32'h0, "data line held after frames");
      verifyAll();
      testDone();
   end
endmodule

`default_nettype wire
